// [hw/poec_top.sv]
// pwm generator output and event stage with apb register slave
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module poec_top
    import poec_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // apb slave
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // generator and control inputs
    input  wire logic              gen_high,
    input  wire logic              gen_low,
    input  wire logic              push_phase,
    input  wire poec_pkg::poec_pci_t pci,
    input  wire poec_pkg::poec_tb_t  tb,
    input  wire logic              debug_halt,
    input  wire logic              duty_write,
    input  wire logic              phase_write,
    input  wire logic              cmpa_write,
    // pins and events
    output logic                   high_pin,
    output logic                   low_pin,
    output logic                   high_pin_en,
    output logic                   low_pin_en,
    output logic                   capture_strobe,
    output logic                   deadtime_comp,
    output logic                   adc_trig1,
    output logic                   adc_trig2,
    output logic                   trig_out,
    output logic                   irq_out,
    output logic                   data_write_block
);
    import poec_pkg::*;

    initial begin
        if (ADDR_W < 5) $error("ADDR_W too small for register map");
    end

    logic [15:0] iol_r, ioh_r, evl_r, evh_r;
    logic [1:0]  ovr_en_r, ovr_dat_r;
    logic        cap_r, upd_r;
    poec_pci_t   pci_q_r;
    logic [4:0]  ofs_cnt_r, ps_cnt_r;
    logic        high_pin_r, low_pin_r, cap_str_r, t1_r, t2_r, trg_r, irq_r, dtc_r;
    logic [1:0]  output_mode_select_r;

    // apb decode, zero wait state
    wire wr_en   = psel && penable && pwrite;
    wire hit_iol = paddr[4:0] == POEC_IOCONL_ADDR[4:0] && paddr[ADDR_W-1:5] == '0;
    wire hit_ioh = paddr[4:0] == POEC_IOCONH_ADDR[4:0] && paddr[ADDR_W-1:5] == '0;
    wire hit_evl = paddr[4:0] == POEC_EVTL_ADDR[4:0] && paddr[ADDR_W-1:5] == '0;
    wire hit_evh = paddr[4:0] == POEC_EVTH_ADDR[4:0] && paddr[ADDR_W-1:5] == '0;
    wire hit_st  = paddr[4:0] == POEC_STAT_ADDR[4:0] && paddr[ADDR_W-1:5] == '0;
    wire hit_any = hit_iol || hit_ioh || hit_evl || hit_evh || hit_st;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit_any;

    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        if (hit_iol) begin
            rd_mux = iol_r;
        end else if (hit_ioh) begin
            rd_mux = ioh_r;
        end else if (hit_evl) begin
            rd_mux = evl_r;
        end else if (hit_evh) begin
            rd_mux = evh_r;
        end else if (hit_st) begin
            rd_mux = 16'h0000;
            rd_mux[POEC_CAP_BIT] = cap_r;
            rd_mux[POEC_UPD_BIT] = upd_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {16'h0000, rd_mux};
        end
    end

    // register fields
    wire         lim_inv   = iol_r[POEC_CURRENT_LIMIT_INVERT_MODE_BIT];
    wire         swap      = iol_r[POEC_SWAP_BIT];
    wire [1:0]   override_sync_select     = iol_r[POEC_OVERRIDE_SYNC_SELECT_LSB +: 2];
    wire [2:0]   capture_source_select    = ioh_r[POEC_CAPTURE_SOURCE_SELECT_LSB +: 3];
    wire [1:0]   output_mode_select      = ioh_r[POEC_OUTPUT_MODE_SELECT_LSB +: 2];
    wire [4:0]   ps        = evl_r[POEC_PS_LSB +: 5];
    wire [2:0]   t1en      = evl_r[POEC_T1EN_LSB +: 3];
    wire [1:0]   auto_update_select    = evl_r[POEC_AUTO_UPDATE_SELECT_LSB +: 2];
    wire [2:0]   trgsel    = evl_r[POEC_TRGSEL_LSB +: 3];
    wire [3:0]   ien       = evh_r[POEC_IEN_LSB +: 4];
    wire [1:0]   ievt      = evh_r[POEC_IEVT_LSB +: 2];
    wire [2:0]   t2en      = evh_r[POEC_T2EN_LSB +: 3];
    wire [4:0]   ofs       = evh_r[POEC_OFS_LSB +: 5];

    // update-pending sources
    wire st_wr     = wr_en && hit_st;
    wire sw_updreq = st_wr && pwdata[POEC_UPDREQ_BIT];
    wire auto_upd  = (auto_update_select == POEC_AUTO_DUTY && duty_write)
                  || (auto_update_select == POEC_AUTO_PHASE && phase_write)
                  || (auto_update_select == POEC_AUTO_CMPA && cmpa_write);
    wire upd_set   = sw_updreq || auto_upd;
    assign data_write_block = upd_r;

    // override latch timing
    wire ovr_load = (override_sync_select == POEC_OVERRIDE_SYNC_SELECT_NOW)
                 || (override_sync_select == POEC_OVERRIDE_SYNC_SELECT_SOC && tb.cycle_start)
                 || (override_sync_select == POEC_OVERRIDE_SYNC_SELECT_UPD && tb.update_done && upd_r);

    // input edges and capture
    wire [3:0] pci_rise = {pci.fault, pci.limit, pci.feedfwd, pci.sync} &
                          ~{pci_q_r.fault, pci_q_r.limit, pci_q_r.feedfwd, pci_q_r.sync};
    logic hw_cap;
    always_comb begin
        case (capture_source_select)
            POEC_CAP_SYNC: hw_cap = pci_rise[0];
            POEC_CAP_FF:   hw_cap = pci_rise[1];
            POEC_CAP_LIM:  hw_cap = pci_rise[2];
            POEC_CAP_FLT:  hw_cap = pci_rise[3];
            default:       hw_cap = 1'b0;
        endcase
    end
    wire sw_cap   = st_wr && pwdata[POEC_CAP_BIT];
    wire cap_fire = (hw_cap || sw_cap) && !cap_r;
    // a capture wins over a software clear of a clear flag; a capture while the flag is set is dropped
    wire cap_nxt  = cap_fire || (cap_r && !(st_wr && !pwdata[POEC_CAP_BIT]));

    // adc trigger sources
    wire [2:0] cmp_ev = {tb.cmp_c, tb.cmp_b, tb.cmp_a};
    wire t1_ev  = |(cmp_ev & t1en);
    wire t2_ev  = |(cmp_ev & t2en);
    wire ofs_done = ofs_cnt_r >= ofs;
    wire t1_pass  = t1_ev && ofs_done && ps_cnt_r == 5'h00;

    // generator signals after output mode
    logic mh, ml;
    always_comb begin
        case (output_mode_select_r)
            POEC_OUTPUT_MODE_SELECT_INDEP: begin
                mh = gen_high;
                ml = gen_low;
            end
            POEC_OUTPUT_MODE_SELECT_PUSH: begin
                mh = gen_high && !push_phase;
                ml = gen_high && push_phase;
            end
            default: begin
                mh = gen_high;
                ml = !gen_high;
            end
        endcase
    end

    // override and priority chain, swap first
    logic ph, pl;
    always_comb begin
        ph = swap ? ml : mh;
        pl = swap ? mh : ml;
        if (ovr_en_r[1]) ph = ovr_dat_r[1];
        if (ovr_en_r[0]) pl = ovr_dat_r[0];
        if (pci.feedfwd) begin
            ph = iol_r[POEC_FEEDFORWARD_LEVELS_LSB + 1];
            pl = iol_r[POEC_FEEDFORWARD_LEVELS_LSB];
        end
        if (pci.limit) begin
            if (lim_inv) begin
                ph = !ph;
                pl = !pl;
            end else begin
                ph = iol_r[POEC_LIMDAT_LSB + 1];
                pl = iol_r[POEC_LIMDAT_LSB];
            end
        end
        if (pci.fault) begin
            ph = iol_r[POEC_FAULT_LEVELS_LSB + 1];
            pl = iol_r[POEC_FAULT_LEVELS_LSB];
        end
        if (debug_halt) begin
            ph = iol_r[POEC_HLTDAT_LSB + 1];
            pl = iol_r[POEC_HLTDAT_LSB];
        end
    end

    logic trg_sel, irq_sel;
    always_comb begin
        case (trgsel)
            POEC_TRG_EOC: trg_sel = tb.cycle_end;
            POEC_TRG_A:   trg_sel = tb.cmp_a;
            POEC_TRG_B:   trg_sel = tb.cmp_b;
            POEC_TRG_C:   trg_sel = tb.cmp_c;
            default:      trg_sel = 1'b0;
        endcase
        case (ievt)
            POEC_IRQ_EOC: irq_sel = tb.cycle_end;
            POEC_IRQ_A:   irq_sel = tb.cmp_a;
            POEC_IRQ_ADC: irq_sel = t1_pass;
            default:      irq_sel = 1'b0;
        endcase
    end
    wire irq_nxt = irq_sel || |(pci_rise & ien);

    // register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            iol_r <= POEC_RESET_VAL;
            ioh_r <= POEC_RESET_VAL;
            evl_r <= POEC_RESET_VAL;
            evh_r <= POEC_RESET_VAL;
        end else if (wr_en) begin
            if (hit_iol) iol_r <= pwdata[15:0];
            if (hit_ioh) ioh_r <= pwdata[15:0] & POEC_IOCONH_MASK;
            if (hit_evl) evl_r <= pwdata[15:0] & POEC_EVTL_MASK;
            if (hit_evh) evh_r <= pwdata[15:0] & POEC_EVTH_MASK;
        end
    end

    // status, override latch and mode hold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_r     <= 1'b0;
            upd_r     <= 1'b0;
            ovr_en_r  <= 2'b00;
            ovr_dat_r <= 2'b00;
            output_mode_select_r    <= POEC_OUTPUT_MODE_SELECT_COMP;
            pci_q_r   <= '0;
        end else begin
            cap_r   <= cap_nxt;
            pci_q_r <= pci;
            // set wins over completion
            upd_r   <= upd_set || (upd_r && !tb.update_done);
            if (ovr_load) begin
                ovr_en_r  <= {iol_r[POEC_OVRH_BIT], iol_r[POEC_OVRL_BIT]};
                ovr_dat_r <= iol_r[POEC_OVERRIDE_LEVELS_LSB +: 2];
            end
            if (output_mode_select != POEC_OUTPUT_MODE_SELECT_RSV) output_mode_select_r <= output_mode_select;
        end
    end

    // adc trigger 1 offset and postscale counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ofs_cnt_r <= 5'h00;
            ps_cnt_r  <= 5'h00;
        end else if (wr_en && (hit_evl || hit_evh)) begin
            // restart counting after reconfiguration
            ofs_cnt_r <= 5'h00;
            ps_cnt_r  <= 5'h00;
        end else if (t1_ev) begin
            if (!ofs_done) begin
                ofs_cnt_r <= ofs_cnt_r + 5'h01;
            end else if (ps_cnt_r >= ps) begin
                ps_cnt_r <= 5'h00;
            end else begin
                ps_cnt_r <= ps_cnt_r + 5'h01;
            end
        end
    end

    // registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_pin_r <= 1'b0;
            low_pin_r  <= 1'b0;
            cap_str_r  <= 1'b0;
            t1_r       <= 1'b0;
            t2_r       <= 1'b0;
            trg_r      <= 1'b0;
            irq_r      <= 1'b0;
            dtc_r      <= 1'b0;
        end else begin
            high_pin_r <= ph ^ ioh_r[POEC_HIGH_POLARITY_BIT];
            low_pin_r  <= pl ^ ioh_r[POEC_POLL_BIT];
            cap_str_r  <= cap_fire;
            t1_r       <= t1_pass;
            t2_r       <= t2_ev;
            trg_r      <= trg_sel;
            irq_r      <= irq_nxt;
            dtc_r      <= ioh_r[POEC_DTC_BIT] ? pci.feedfwd : pci.sync;
        end
    end

    assign high_pin       = high_pin_r;
    assign low_pin        = low_pin_r;
    // enable is low while the generator drives the pin
    assign high_pin_en    = !ioh_r[POEC_HIGH_PIN_ENABLE_BIT];
    assign low_pin_en     = !ioh_r[POEC_LOW_PIN_ENABLE_BIT];
    assign capture_strobe = cap_str_r;
    assign adc_trig1      = t1_r;
    assign adc_trig2      = t2_r;
    assign trig_out       = trg_r;
    assign irq_out        = irq_r;
    assign deadtime_comp  = dtc_r;
endmodule
`default_nettype wire

// [inc/poec_pkg.sv]
// package: register map, field positions and codes for the pwm output and event stage
package poec_pkg;
    // register byte addresses
    localparam logic [11:0] POEC_IOCONL_ADDR = 12'h000;
    localparam logic [11:0] POEC_IOCONH_ADDR = 12'h004;
    localparam logic [11:0] POEC_EVTL_ADDR   = 12'h008;
    localparam logic [11:0] POEC_EVTH_ADDR   = 12'h00C;
    localparam logic [11:0] POEC_STAT_ADDR   = 12'h010;
    localparam logic [15:0] POEC_RESET_VAL   = 16'h0000;
    // io control low fields
    localparam int POEC_CURRENT_LIMIT_INVERT_MODE_BIT  = 15;
    localparam int POEC_SWAP_BIT   = 14;
    localparam int POEC_OVRH_BIT   = 13;
    localparam int POEC_OVRL_BIT   = 12;
    localparam int POEC_OVERRIDE_LEVELS_LSB = 10;
    localparam int POEC_OVERRIDE_SYNC_SELECT_LSB  = 8;
    localparam int POEC_FAULT_LEVELS_LSB = 6;
    localparam int POEC_LIMDAT_LSB = 4;
    localparam int POEC_FEEDFORWARD_LEVELS_LSB  = 2;
    localparam int POEC_HLTDAT_LSB = 0;
    // io control high fields
    localparam int POEC_CAPTURE_SOURCE_SELECT_LSB = 12;
    localparam int POEC_DTC_BIT    = 8;
    localparam int POEC_OUTPUT_MODE_SELECT_LSB   = 4;
    localparam int POEC_HIGH_PIN_ENABLE_BIT   = 3;
    localparam int POEC_LOW_PIN_ENABLE_BIT   = 2;
    localparam int POEC_HIGH_POLARITY_BIT   = 1;
    localparam int POEC_POLL_BIT   = 0;
    localparam logic [15:0] POEC_IOCONH_MASK = 16'h713F;
    // event low fields
    localparam int POEC_PS_LSB     = 11;
    localparam int POEC_T1EN_LSB   = 8;
    localparam int POEC_AUTO_UPDATE_SELECT_LSB = 3;
    localparam int POEC_TRGSEL_LSB = 0;
    localparam logic [15:0] POEC_EVTL_MASK = 16'hFF1F;
    // event high fields
    localparam int POEC_IEN_LSB    = 12;
    localparam int POEC_IEVT_LSB   = 8;
    localparam int POEC_T2EN_LSB   = 5;
    localparam int POEC_OFS_LSB    = 0;
    localparam logic [15:0] POEC_EVTH_MASK = 16'hF3FF;
    // status register bits
    localparam int POEC_CAP_BIT    = 5;
    localparam int POEC_UPD_BIT    = 4;
    localparam int POEC_UPDREQ_BIT = 3;

    typedef enum logic [1:0] {POEC_OVERRIDE_SYNC_SELECT_SOC, POEC_OVERRIDE_SYNC_SELECT_NOW, POEC_OVERRIDE_SYNC_SELECT_UPD, POEC_OVERRIDE_SYNC_SELECT_RSV} poec_override_sync_select_t;
    typedef enum logic [1:0] {POEC_OUTPUT_MODE_SELECT_COMP, POEC_OUTPUT_MODE_SELECT_INDEP, POEC_OUTPUT_MODE_SELECT_PUSH, POEC_OUTPUT_MODE_SELECT_RSV} poec_output_mode_select_t;
    typedef enum logic [1:0] {POEC_AUTO_NONE, POEC_AUTO_DUTY, POEC_AUTO_PHASE, POEC_AUTO_CMPA} poec_auto_t;
    localparam logic [2:0] POEC_CAP_SW   = 3'h0;
    localparam logic [2:0] POEC_CAP_SYNC = 3'h1;
    localparam logic [2:0] POEC_CAP_FF   = 3'h2;
    localparam logic [2:0] POEC_CAP_LIM  = 3'h3;
    localparam logic [2:0] POEC_CAP_FLT  = 3'h4;
    localparam logic [2:0] POEC_TRG_EOC  = 3'h0;
    localparam logic [2:0] POEC_TRG_A    = 3'h1;
    localparam logic [2:0] POEC_TRG_B    = 3'h2;
    localparam logic [2:0] POEC_TRG_C    = 3'h3;
    localparam logic [1:0] POEC_IRQ_EOC  = 2'h0;
    localparam logic [1:0] POEC_IRQ_A    = 2'h1;
    localparam logic [1:0] POEC_IRQ_ADC  = 2'h2;

    // control inputs from the input qualification logic
    typedef struct packed {
        logic fault;
        logic limit;
        logic feedfwd;
        logic sync;
    } poec_pci_t;

    // time base events from the duty-cycle core
    typedef struct packed {
        logic cycle_start;
        logic cycle_end;
        logic cmp_a;
        logic cmp_b;
        logic cmp_c;
        logic update_done;
    } poec_tb_t;
endpackage

// [testbench/poec_assertions.sv]
// checker of pin levels, events and register effects at the top ports
`timescale 1ns/10ps
`default_nettype none
module poec_assertions
    import poec_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // apb
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [ADDR_W-1:0]   paddr,
    input wire logic [31:0]         pwdata,
    input wire logic                pready,
    input wire logic                pslverr,
    // control and events
    input wire poec_pkg::poec_pci_t pci,
    input wire poec_pkg::poec_tb_t  tb,
    input wire logic                debug_halt,
    input wire logic                duty_write,
    // pins and events
    input wire logic                high_pin,
    input wire logic                low_pin,
    input wire logic                high_pin_en,
    input wire logic                low_pin_en,
    input wire logic                deadtime_comp,
    input wire logic                adc_trig2,
    input wire logic                trig_out,
    input wire logic                irq_out,
    input wire logic                data_write_block
);
    // shadow of the control registers, updated only by completed writes
    logic [15:0] iol_r;
    logic [15:0] ioh_r;
    logic [15:0] evl_r;
    logic [15:0] evh_r;
    wire logic   wr = psel & penable & pwrite & pready & ~pslverr;
    wire logic   dsrc = ioh_r[8] ? pci.feedfwd : pci.sync;
    wire logic   t2 = (evh_r[7] & tb.cmp_c) | (evh_r[6] & tb.cmp_b) | (evh_r[5] & tb.cmp_a);
    wire logic   quiet = !wr && ioh_r[1:0] == 2'b00;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {iol_r, ioh_r, evl_r, evh_r} <= 64'h0;
        end else if (wr) begin
            if (paddr == ADDR_W'(POEC_IOCONL_ADDR)) iol_r <= pwdata[15:0];
            if (paddr == ADDR_W'(POEC_IOCONH_ADDR)) ioh_r <= pwdata[15:0];
            if (paddr == ADDR_W'(POEC_EVTL_ADDR)) evl_r <= pwdata[15:0];
            if (paddr == ADDR_W'(POEC_EVTH_ADDR)) evh_r <= pwdata[15:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    pin_enable_a: assert property (high_pin_en == !ioh_r[3] && low_pin_en == !ioh_r[2])
        else $error("pin enable differs from its bit");
    fault_level_a: assert property (quiet && pci.fault && !debug_halt |=> {high_pin, low_pin} == iol_r[7:6])
        else $error("fault levels not on pins");
    limit_level_a: assert property (quiet && pci.limit && !pci.fault && !debug_halt && !iol_r[15]
        |=> {high_pin, low_pin} == iol_r[5:4]) else $error("limit levels not on pins");
    ff_level_a: assert property (quiet && pci.feedfwd && !pci.limit && !pci.fault && !debug_halt
        |=> {high_pin, low_pin} == iol_r[3:2]) else $error("feed-forward levels not on pins");
    halt_level_a: assert property (quiet && debug_halt |=> {high_pin, low_pin} == iol_r[1:0])
        else $error("halt levels not on pins");
    deadtime_src_a: assert property (!wr |=> deadtime_comp == $past(dsrc))
        else $error("dead-time compensation source wrong");
    input_irq_a: assert property (!wr && evh_r[15] && $rose(pci.fault) |=> irq_out)
        else $error("no interrupt on fault edge");
    trig_sel_a: assert property (!wr && evl_r[2:0] == POEC_TRG_A |=> trig_out == $past(tb.cmp_a))
        else $error("trigger output not compare a");
    adc2_feed_a: assert property (!wr |=> adc_trig2 == $past(t2))
        else $error("adc trigger 2 mismatch");
    auto_update_a: assert property (!wr && duty_write && evl_r[4:3] == 2'b01 |=> data_write_block)
        else $error("duty write did not set pending");
endmodule
bind poec_top poec_assertions #(.ADDR_W(ADDR_W)) chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .pslverr, .pci, .tb, .debug_halt, .duty_write, .high_pin, .low_pin, .high_pin_en,
    .low_pin_en, .deadtime_comp, .adc_trig2, .trig_out, .irq_out, .data_write_block);
`default_nettype wire

// [testbench/poec_gate_model.sv]
// gate driver inputs and adc trigger inputs behind the stage
`timescale 1ns/10ps
`default_nettype none
module poec_gate_model (
    // clock
    input  wire logic pclk,
    // pins
    input  wire logic high_pin,
    input  wire logic low_pin,
    input  wire logic high_pin_en,
    input  wire logic low_pin_en,
    input  wire logic adc_trig1,
    input  wire logic adc_trig2,
    // seen levels and trigger counts
    output logic      gate_h,
    output logic      gate_l,
    output int        n_adc1,
    output int        n_adc2
);
    // one driver per counter: start value given where it is declared
    int cnt1 = 0;
    int cnt2 = 0;
    // an undriven pin falls to the driver's pull-down
    assign gate_h = high_pin_en ? 1'b0 : high_pin;
    assign gate_l = low_pin_en ? 1'b0 : low_pin;
    assign n_adc1 = cnt1;
    assign n_adc2 = cnt2;
    always @(posedge pclk) begin
        cnt1 <= cnt1 + int'(adc_trig1 === 1'b1);
        cnt2 <= cnt2 + int'(adc_trig2 === 1'b1);
    end
endmodule
`default_nettype wire

// [testbench/test_pwm_output_event_control.sv]
// self-checking testbench of the pwm output and event stage
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; $display("unexpected %s exp %0h got %0h", n, e, g); end end
module test_pwm_output_event_control;
    import poec_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic        pready, pslverr, err, hpe, lpe, hp, lp, cap, dtc, at1, at2, trg, irq, dwb, gh, gl;
    logic        gen_high = 1'b0, gen_low = 1'b0, push_phase = 1'b0, debug_halt = 1'b0;
    logic [2:0]  dw = 3'h0;
    poec_pci_t   pci = '0;
    poec_tb_t    tb = '0;
    logic [15:0] rd;
    int          miscompares = 0, num_checks = 0, cyc = 0, n_cap = 0, n_trg = 0, n_irq = 0, n1, n2, c, d, e;
    logic [11:0] adr [5] = '{POEC_IOCONL_ADDR, POEC_IOCONH_ADDR, POEC_EVTL_ADDR, POEC_EVTH_ADDR, POEC_STAT_ADDR};
    logic [15:0] msk [4] = '{16'hFFFF, POEC_IOCONH_MASK, POEC_EVTL_MASK, POEC_EVTH_MASK};
    logic [3:0]  pv [4] = '{4'h2, 4'h6, 4'hE, 4'hE};
    logic [2:0]  ex [4] = '{3'h0, 3'h4, 3'h2, 3'h6};
    always #50 pclk = ~pclk;
    poec_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .gen_high, .gen_low, .push_phase, .pci, .tb, .debug_halt, .duty_write(dw[0]), .phase_write(dw[1]),
        .cmpa_write(dw[2]), .high_pin(hp), .low_pin(lp), .high_pin_en(hpe), .low_pin_en(lpe),
        .capture_strobe(cap), .deadtime_comp(dtc), .adc_trig1(at1), .adc_trig2(at2), .trig_out(trg),
        .irq_out(irq), .data_write_block(dwb));
    poec_gate_model gate_u (.pclk, .high_pin(hp), .low_pin(lp), .high_pin_en(hpe), .low_pin_en(lpe),
        .adc_trig1(at1), .adc_trig2(at2), .gate_h(gh), .gate_l(gl), .n_adc1(n1), .n_adc2(n2));
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] v);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, v};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata[15:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdk(input logic [11:0] a, input logic [15:0] e);
        apb(1'b0, a, 16'h0000);
        `CHK("read data", e, rd)
    endtask
    // pins are registered: look two edges later once settled, leave on an edge
    task automatic lv(input logic [2:0] e);
        repeat (2) @(posedge pclk);
        #1;
        `CHK("pins and dtc", e, {gh, gl, dtc})
        @(posedge pclk);
    endtask
    task automatic tp(input int b);
        tb[b] <= 1'b1;
        @(posedge pclk);
        tb[b] <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic pp(input int b);
        pci[b] <= 1'b1;
        repeat (3) @(posedge pclk);
        pci[b] <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    task automatic endt(input string s);
        $display("test %s finished", s);
    endtask
    always @(posedge pclk) begin
        cyc++;
        n_cap += int'(cap === 1'b1);
        n_trg += int'(trg === 1'b1);
        n_irq += int'(irq === 1'b1);
        if (cyc > 5000) begin
            miscompares++;
            summarize();
        end
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) rdk(adr[i], 16'h0000);
        apb(1'b1, 12'h014, 16'hFFFF);
        `CHK("slave error", 1'b1, err)
        rdk(12'h014, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, adr[i], 16'hFFFF);
            rdk(adr[i], msk[i]);
            apb(1'b1, adr[i], 16'h0000);
        end
        tp(5);
        endt("registers");
        gen_high <= 1'b1;
        gen_low <= 1'b1;
        apb(1'b1, adr[1], 16'h0010);
        lv(3'h0);
        apb(1'b1, adr[1], 16'h001C);
        lv(3'h6);
        gen_low <= 1'b0;
        lv(3'h4);
        apb(1'b1, adr[0], 16'h4000);
        lv(3'h2);
        apb(1'b1, adr[0], 16'h0000);
        apb(1'b1, adr[1], 16'h001F);
        lv(3'h2);
        apb(1'b1, adr[1], 16'h000C);
        gen_low <= 1'b1;
        lv(3'h4);
        apb(1'b1, adr[1], 16'h002C);
        lv(3'h4);
        push_phase <= 1'b1;
        lv(3'h2);
        apb(1'b1, adr[1], 16'h003C);
        lv(3'h2);
        apb(1'b1, adr[1], 16'h001C);
        gen_high <= 1'b0;
        gen_low <= 1'b0;
        apb(1'b1, adr[0], 16'h3900);
        lv(3'h4);
        apb(1'b1, adr[0], 16'h0100);
        apb(1'b1, adr[0], 16'h3400);
        lv(3'h0);
        tp(5);
        lv(3'h2);
        apb(1'b1, adr[0], 16'h3200);
        lv(3'h2);
        apb(1'b1, adr[4], 16'h0008);
        tp(0);
        lv(3'h0);
        apb(1'b1, adr[0], 16'h0000);
        tp(5);
        gen_high <= 1'b1;
        gen_low <= 1'b1;
        apb(1'b1, adr[0], 16'h0063);
        for (int i = 0; i < 4; i++) begin
            pci <= pv[i];
            debug_halt <= (i == 3);
            lv(ex[i]);
        end
        debug_halt <= 1'b0;
        pci <= 4'h0;
        apb(1'b1, adr[0], 16'h8063);
        pci <= 4'h4;
        lv(3'h0);
        apb(1'b1, adr[1], 16'h011C);
        pci <= 4'h2;
        lv(3'h1);
        pci <= 4'h1;
        lv(3'h6);
        pci <= 4'h0;
        endt("pins");
        for (int k = 1; k < 6; k++) begin
            apb(1'b1, adr[1], {1'b0, 3'(k), 12'h01C});
            apb(1'b1, adr[4], 16'h0000);
            c = n_cap;
            pp((k == 5) ? 0 : k - 1);
            `CHK("capture", (k < 5) ? 1 : 0, n_cap - c)
        end
        apb(1'b1, adr[1], 16'h001C);
        apb(1'b1, adr[4], 16'h0000);
        c = n_cap;
        apb(1'b1, adr[4], 16'h0020);
        repeat (3) @(posedge pclk);
        `CHK("soft capture", 1, n_cap - c)
        endt("capture");
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, adr[2], 16'(i));
            apb(1'b1, adr[3], 16'((i % 4) << 8));
            c = n_trg;
            d = n_irq;
            for (int b = 4; b > 0; b--) tp(b);
            `CHK("trigger", (i < 4) ? 1 : 0, n_trg - c)
            `CHK("time base irq", (i % 4 < 2) ? 1 : 0, n_irq - d)
        end
        apb(1'b1, adr[3], 16'hF300);
        d = n_irq;
        for (int b = 0; b < 4; b++) pp(b);
        `CHK("input irq", 4, n_irq - d)
        apb(1'b1, adr[3], 16'h0300);
        d = n_irq;
        pp(3);
        `CHK("masked irq", 0, n_irq - d)
        endt("events");
        // offset 2, postscale 1:2, trigger 1 from compare a, trigger 2 from compare b, irq on trigger 1
        apb(1'b1, adr[3], 16'h0242);
        apb(1'b1, adr[2], 16'h0900);
        c = n1;
        d = n2;
        e = n_irq;
        for (int i = 0; i < 8; i++) begin
            tp(3);
            tp(2);
        end
        `CHK("adc trigger 1", (8 - 2 + 1) / 2, n1 - c)
        `CHK("adc trigger 2", 8, n2 - d)
        `CHK("adc trigger irq", (8 - 2 + 1) / 2, n_irq - e)
        endt("adc");
        apb(1'b1, adr[4], 16'h0000);
        for (int k = 1; k < 4; k++) begin
            apb(1'b1, adr[2], 16'(k << 3));
            for (int j = 0; j < 3; j++) begin
                dw[j] <= 1'b1;
                @(posedge pclk);
                dw[j] <= 1'b0;
                rdk(adr[4], (j >= k - 1) ? 16'h0010 : 16'h0000);
            end
            tp(0);
            rdk(adr[4], 16'h0000);
        end
        apb(1'b1, adr[2], 16'h0000);
        apb(1'b1, adr[4], 16'h0008);
        rdk(adr[4], 16'h0010);
        endt("update");
        summarize();
    end
endmodule
`default_nettype wire
